// ### rtl/ddr2_init_pkg.sv
// Purpose: shared constants for the power-up and mode-register link
// Assumes: 100 MHz CLK, command bus sampled on the rising edge
// Notes:   device end and controller end both import this package
package ddr2_init_pkg;
    localparam int CLK_MHZ            = 100;     // CLK rate in MHz
    localparam int ADDR_W             = 14;      // address pins A0-A13
    localparam int STABLE_US          = 200;     // power/clock stable wait
    localparam int CKE_NOP_NS         = 400;     // nop wait after cke rises
    localparam int DLL_LOCK_CLKS      = 200;     // clocks after dll reset before calibration
    localparam int MIN_REFRESH        = 2;       // auto-refresh count
    localparam int TOFF_HALF_CYCLES   = 5;       // termination_off_delay 2.5 clocks, in half cycles
    localparam int STABLE_CYC         = STABLE_US * CLK_MHZ;
    localparam int CKE_NOP_CYC        = (CKE_NOP_NS * CLK_MHZ + 999) / 1000;
    localparam int TOFF_CYC           = (TOFF_HALF_CYCLES + 1) / 2;
    localparam int CNT_W              = 16;      // wait counter width
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP    = 4'h7;
    localparam logic [3:0] CMD_DESEL  = 4'h8;
    localparam logic [3:0] CMD_PREALL = 4'h2;
    localparam logic [3:0] CMD_REF    = 4'h1;
    localparam logic [3:0] CMD_MRS    = 4'h0;
    // mode register selects on the bank pins
    localparam logic [1:0] BANK_MR    = 2'h0;
    localparam logic [1:0] BANK_EMR1  = 2'h1;
    localparam logic [1:0] BANK_EMR2  = 2'h2;
    localparam logic [1:0] BANK_EMR3  = 2'h3;
    // field positions
    localparam int BIT_PREALL         = 10;      // A10 selects all banks
    localparam int BIT_TEST           = 7;       // A7 test mode in MR
    localparam int BIT_DLL_RST        = 8;       // A8 dll reset in MR
    localparam int BIT_DLL_DIS        = 0;       // A0 dll disable in EMR(1)
    localparam logic [13:0] OCD_MASK  = 14'h0380; // A9:A7 in EMR(1)
    localparam logic [13:0] ZERO_ADDR = 14'h0000;
endpackage : ddr2_init_pkg

// ### rtl/ddr2_link_if.sv
// Purpose: command/address link between controller and memory device
// Assumes: single clock CLK driven by the system
// Notes:   no two-way pins on this link
`timescale 1ns/1ps
interface ddr2_link_if;
    logic        cke;      // clock enable
    logic        odt;      // on-die termination request
    logic        cs_n;     // chip select, active low
    logic        ras_n;    // row strobe, active low
    logic        cas_n;    // column strobe, active low
    logic        we_n;     // write enable, active low
    logic [1:0]  ba;       // bank / register select
    logic [13:0] addr;     // address / register value
    modport ctrl (output cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport mem  (input  cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : ddr2_link_if

// ### rtl/ddr2_init_ctrl.sv
// Purpose: controller end, power-up sequencer plus Avalon-MM control registers
// Assumes: CLK is also the memory clock, so it runs from reset on
// Notes:   reg 0 ctrl (bit0 start), 1 status, 2 MR value, 3 EMR1, 4 EMR2, 5 EMR3
`timescale 1ns/1ps
module ddr2_init_ctrl
    import ddr2_init_pkg::*;
#(
    parameter int STABLE_CYCLES = STABLE_CYC  // long wait, shorten in sim
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [2:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    ddr2_link_if.ctrl        link
);
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_MR   = 3'h2;
    localparam logic [2:0] REG_EMR1 = 3'h3;
    localparam logic [2:0] REG_EMR2 = 3'h4;
    localparam logic [2:0] REG_EMR3 = 3'h5;

    typedef enum logic [3:0] {
        S_IDLE   = 4'h0, S_STABLE = 4'h1, S_CKE   = 4'h3, S_EMR2   = 4'h2,
        S_EMR3   = 4'h6, S_EMR1   = 4'h7, S_MRDLL = 4'h5, S_PRE2   = 4'h4,
        S_REF    = 4'hC, S_MROP   = 4'hD, S_DLLW  = 4'hF, S_OCDDEF = 4'hE,
        S_OCDX   = 4'hA, S_DONE   = 4'hB
    } state_t;

    state_t            state_q;          // sequencer state
    logic [CNT_W-1:0]  wait_q;           // step wait counter
    logic [CNT_W-1:0]  dll_q;            // clocks since dll reset
    logic [1:0]        ref_q;            // refreshes issued
    logic              start_q;          // software start request
    logic              busy_q;           // sequence running
    logic              done_q;           // sequence complete
    logic [13:0]       mr_q, emr1_q, emr2_q, emr3_q;  // full register images
    logic              ack_q;            // bus answer stage
    logic [31:0]       rd_mux;           // register selected by the bus address
    logic [3:0]        cmd_q;            // command pins
    logic [1:0]        ba_q;
    logic [13:0]       addr_q;
    logic              cke_q;

    // one wait state; read data is captured with the request so it stands, from a flop, at the answer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack_q           <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
        end else begin
            ack_q           <= (AVS_READ || AVS_WRITE) && !ack_q;
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
            if (AVS_READ && !ack_q) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    // register writes land at the acknowledging edge
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            start_q <= 1'b0;
            mr_q    <= ZERO_ADDR;
            emr1_q  <= ZERO_ADDR;
            emr2_q  <= ZERO_ADDR;
            emr3_q  <= ZERO_ADDR;
        end else begin
            if (start_q && state_q == S_IDLE) begin
                start_q <= 1'b0;                          // consumed at the edge that leaves idle
            end
            if (ack_q && AVS_WRITE) begin
                if (AVS_ADDRESS == REG_CTRL) begin
                    start_q <= AVS_WRITEDATA[0];
                end else if (AVS_ADDRESS == REG_MR) begin
                    mr_q <= AVS_WRITEDATA[13:0] & ~(14'h0001 << BIT_TEST);
                end else if (AVS_ADDRESS == REG_EMR1) begin
                    emr1_q <= AVS_WRITEDATA[13:0];        // whole register image
                end else if (AVS_ADDRESS == REG_EMR2) begin
                    emr2_q <= AVS_WRITEDATA[13:0];
                end else if (AVS_ADDRESS == REG_EMR3) begin
                    emr3_q <= AVS_WRITEDATA[13:0];
                end
            end
        end
    end

    // read mux, unmapped reads return zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (AVS_ADDRESS == REG_CTRL) begin
            rd_mux[0] = start_q;
        end else if (AVS_ADDRESS == REG_STAT) begin
            rd_mux[1:0] = {done_q, busy_q};
            rd_mux[7:4] = state_q;
        end else if (AVS_ADDRESS == REG_MR) begin
            rd_mux[13:0] = mr_q;
        end else if (AVS_ADDRESS == REG_EMR1) begin
            rd_mux[13:0] = emr1_q;
        end else if (AVS_ADDRESS == REG_EMR2) begin
            rd_mux[13:0] = emr2_q;
        end else if (AVS_ADDRESS == REG_EMR3) begin
            rd_mux[13:0] = emr3_q;
        end
    end

    // dll lock counter runs from the dll-reset write; saturates
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dll_q <= '0;
        end else if (state_q == S_MRDLL) begin
            dll_q <= '0;
        end else if (dll_q != CNT_W'(DLL_LOCK_CLKS)) begin
            dll_q <= dll_q + 1'b1;
        end
    end

    // sequencer: a step advances only after a cycle that issued nothing, and a nop always follows a command so none run back to back
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            wait_q  <= '0;
            ref_q   <= '0;
            cke_q   <= 1'b0;
            cmd_q   <= CMD_DESEL;
            ba_q    <= BANK_MR;
            addr_q  <= ZERO_ADDR;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            cmd_q  <= CMD_NOP;
            ba_q   <= BANK_MR;
            addr_q <= ZERO_ADDR;
            wait_q <= wait_q + 1'b1;
            if (cmd_q[3] || (cmd_q == CMD_NOP)) begin     // last cycle issued nothing: step on
                case (state_q)
                    S_IDLE: begin
                        cmd_q  <= CMD_DESEL;
                        wait_q <= '0;
                        if (start_q) begin                // clock already running
                            state_q <= S_STABLE;
                            busy_q  <= 1'b1;
                            done_q  <= 1'b0;
                            cke_q   <= 1'b0;
                        end
                    end
                    S_STABLE: begin
                        if (wait_q >= CNT_W'(STABLE_CYCLES - 1)) begin
                            cke_q   <= 1'b1;
                            wait_q  <= '0;
                            state_q <= S_CKE;
                        end
                    end
                    S_CKE: begin
                        if (wait_q >= CNT_W'(CKE_NOP_CYC - 1)) begin
                            cmd_q   <= CMD_PREALL;
                            addr_q  <= ZERO_ADDR | (14'h0001 << BIT_PREALL);
                            state_q <= S_EMR2;
                        end
                    end
                    S_EMR2: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_EMR2;
                        addr_q  <= emr2_q;
                        state_q <= S_EMR3;
                    end
                    S_EMR3: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_EMR3;
                        addr_q  <= emr3_q;
                        state_q <= S_EMR1;
                    end
                    S_EMR1: begin
                        cmd_q   <= CMD_MRS;               // dll enable, ocd bits off
                        ba_q    <= BANK_EMR1;
                        addr_q  <= emr1_q & ~OCD_MASK & ~(14'h0001 << BIT_DLL_DIS);
                        state_q <= S_MRDLL;
                    end
                    S_MRDLL: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_MR;
                        addr_q  <= mr_q | (14'h0001 << BIT_DLL_RST);
                        state_q <= S_PRE2;
                    end
                    S_PRE2: begin
                        cmd_q   <= CMD_PREALL;
                        addr_q  <= ZERO_ADDR | (14'h0001 << BIT_PREALL);
                        ref_q   <= '0;
                        state_q <= S_REF;
                    end
                    S_REF: begin
                        cmd_q <= CMD_REF;
                        ref_q <= ref_q + 1'b1;
                        if (ref_q == 2'(MIN_REFRESH - 1)) begin
                            state_q <= S_MROP;
                        end
                    end
                    S_MROP: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_MR;
                        addr_q  <= mr_q & ~(14'h0001 << BIT_DLL_RST);
                        state_q <= S_DLLW;
                    end
                    S_DLLW: begin
                        if (dll_q == CNT_W'(DLL_LOCK_CLKS)) begin
                            state_q <= S_OCDDEF;
                        end
                    end
                    S_OCDDEF: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_EMR1;
                        addr_q  <= (emr1_q & ~(14'h0001 << BIT_DLL_DIS)) | OCD_MASK;
                        state_q <= S_OCDX;
                    end
                    S_OCDX: begin
                        cmd_q   <= CMD_MRS;
                        ba_q    <= BANK_EMR1;
                        addr_q  <= emr1_q & ~OCD_MASK & ~(14'h0001 << BIT_DLL_DIS);
                        state_q <= S_DONE;
                    end
                    S_DONE: begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    assign link.cke   = cke_q;
    assign link.odt   = 1'b0;                             // termination off through init
    assign link.cs_n  = cmd_q[3];
    assign link.ras_n = cmd_q[2];
    assign link.cas_n = cmd_q[1];
    assign link.we_n  = cmd_q[0];
    assign link.ba    = ba_q;
    assign link.addr  = addr_q;
endmodule : ddr2_init_ctrl

// ### rtl/ddr2_init_mem.sv
// Purpose: memory device end: decodes register sets and tracks init state
// Assumes: link signals are produced on CLK by the controller end
// Notes:   array contents are not modelled; only register state is kept
`timescale 1ns/1ps
module ddr2_init_mem
    import ddr2_init_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    ddr2_link_if.mem         link,
    output logic             READY,        // normal commands accepted
    output logic             DLL_RESET,    // one-cycle pulse on dll reset
    output logic             ODT_ACTIVE,   // termination on, off delayed
    output logic [13:0]      MR_OUT,
    output logic [13:0]      EMR1_OUT,
    output logic [13:0]      EMR2_OUT,
    output logic [13:0]      EMR3_OUT
);
    logic [3:0]  cmd;                      // decoded command pins
    logic        is_set;                   // register-set strobe
    logic [3:0]  written_q;                // which registers were set
    logic        ocd_def_q;                // calibration default seen
    logic [1:0]  toff_q;                   // termination off countdown
    assign cmd    = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign is_set = link.cke && (cmd == CMD_MRS);

    // register images, whole value replaces old
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MR_OUT   <= ZERO_ADDR;
            EMR1_OUT <= ZERO_ADDR;
            EMR2_OUT <= ZERO_ADDR;
            EMR3_OUT <= ZERO_ADDR;
            DLL_RESET <= 1'b0;
        end else begin
            DLL_RESET <= is_set && (link.ba == BANK_MR) && link.addr[BIT_DLL_RST];
            if (is_set) begin                      // no array side effect
                if (link.ba == BANK_MR) begin
                    MR_OUT <= link.addr;
                end else if (link.ba == BANK_EMR1) begin
                    EMR1_OUT <= link.addr;
                end else if (link.ba == BANK_EMR2) begin
                    EMR2_OUT <= link.addr;
                end else begin
                    EMR3_OUT <= link.addr;
                end
            end
        end
    end

    // ready once all four set and calibration exited
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            written_q <= 4'h0;
            ocd_def_q <= 1'b0;
            READY     <= 1'b0;
        end else if (is_set) begin
            written_q[link.ba] <= 1'b1;
            if (link.ba == BANK_EMR1 && (link.addr & OCD_MASK) == OCD_MASK) begin
                ocd_def_q <= 1'b1;
            end else if (link.ba == BANK_EMR1 && (link.addr & OCD_MASK) == ZERO_ADDR && ocd_def_q) begin
                READY <= &written_q;
            end
        end
    end

    // termination turns off after whole-cycle rounding of 2.5 clocks
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ODT_ACTIVE <= 1'b0;
            toff_q     <= 2'h0;
        end else if (link.odt) begin
            ODT_ACTIVE <= 1'b1;
            toff_q     <= 2'(TOFF_CYC);
        end else if (toff_q != 2'h0) begin
            toff_q <= toff_q - 1'b1;
            if (toff_q == 2'h1) begin
                ODT_ACTIVE <= 1'b0;
            end
        end
    end
endmodule : ddr2_init_mem

// ### tb/ddr2_init_assertions.sv
// Purpose: checks the controller side of the power-up link cycle by cycle
// Assumes: link signals sampled on the rising edge of CLK, sync active-low reset
// Notes:   helper counters stand in for long waits that repetition cannot express
`timescale 1ns/1ps
module ddr2_init_assertions
    import ddr2_init_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        cke,
    input wire logic        odt,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [13:0] addr
);
    wire logic [3:0]  cmd   = {cs_n, ras_n, cas_n, we_n};  // command code on the bus
    wire logic        idle  = cs_n || (cmd == CMD_NOP);    // nop or deselect
    wire logic        set_w = cke && (cmd == CMD_MRS);     // register set seen by the device
    logic [CNT_W-1:0] cke_cnt_q;                           // cycles since cke went high
    logic [CNT_W-1:0] dll_cnt_q;                           // cycles since dll reset, 0 = none yet
    logic             emr2_q;                              // EMR(2) already written
    logic             emr1_q;                              // EMR(1) written with dll on
    logic [1:0]       ref_q;                               // refreshes seen, saturates at 2

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // count cycles with cke high; saturation keeps a long run from wrapping back into the wait
    always_ff @(posedge CLK) begin
        if (!RST_N || !cke) begin
            cke_cnt_q <= '0;
        end else if (cke_cnt_q != '1) begin
            cke_cnt_q <= cke_cnt_q + 1'b1;
        end
    end

    // dll lock timer starts at the mode register write that requests dll reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dll_cnt_q <= '0;
        end else if (set_w && ba == BANK_MR && addr[BIT_DLL_RST]) begin
            dll_cnt_q <= 16'h0001;
        end else if (dll_cnt_q != '0 && dll_cnt_q != '1) begin
            dll_cnt_q <= dll_cnt_q + 1'b1;
        end
    end

    // order flags for the sequence steps
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            emr2_q <= 1'b0;
            emr1_q <= 1'b0;
            ref_q  <= 2'h0;
        end else begin
            if (set_w && ba == BANK_EMR2) emr2_q <= 1'b1;
            if (set_w && ba == BANK_EMR1 && !addr[BIT_DLL_DIS]) emr1_q <= 1'b1;
            if (cke && cmd == CMD_REF && ref_q != 2'h2) ref_q <= ref_q + 2'h1;
        end
    end

    AST_ODT_LOW: assert property (odt == 1'b0) else $error("odt driven high during init");
    AST_IDLE_CKE_LOW: assert property (!cke |-> idle) else $error("command while cke low");
    AST_CKE_RISE_NOP: assert property ($rose(cke) |-> idle) else $error("cke rose without nop");
    AST_CKE_NOP_WAIT: assert property (cke && cke_cnt_q < CKE_NOP_CYC |-> idle)
        else $error("command inside the nop wait after cke");
    AST_CMD_ONE_CYCLE: assert property (cke && !idle |=> idle) else $error("command not followed by nop");
    AST_PREALL_A10: assert property (cke && cmd == CMD_PREALL |-> addr[BIT_PREALL])
        else $error("precharge without all-bank bit");
    AST_EMR3_AFTER_EMR2: assert property (set_w && ba == BANK_EMR3 |-> emr2_q)
        else $error("EMR3 before EMR2");
    AST_DLLRST_AFTER_EMR1: assert property (set_w && ba == BANK_MR && addr[BIT_DLL_RST] |-> emr1_q)
        else $error("dll reset before dll enable");
    AST_MR_TEST_LOW: assert property (set_w && ba == BANK_MR |-> !addr[BIT_TEST])
        else $error("mode write with test bit");
    AST_OPS_AFTER_REF: assert property (set_w && ba == BANK_MR && !addr[BIT_DLL_RST] |-> ref_q == 2'h2)
        else $error("operating mode write before two refreshes");
    AST_OCD_AFTER_LOCK: assert property (set_w && ba == BANK_EMR1 && (addr & OCD_MASK) == OCD_MASK
        |-> dll_cnt_q >= DLL_LOCK_CLKS) else $error("calibration too soon after dll reset");
endmodule : ddr2_init_assertions

// ### tb/testbench.sv
// Purpose: drives the controller over Avalon-MM and checks both link ends
// Assumes: shortened stable wait, one 100 MHz clock
// Notes:   a monitor logs every non-nop command on the link for ordering checks
`timescale 1ns/1ps
module testbench;
    import ddr2_init_pkg::*;
    localparam int STAB = 50;          // shortened power/clock stable wait
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        ready, dll_reset, odt_active;
    logic [13:0] mr_out, emr1_out, emr2_out, emr3_out;
    int          n_mismatch, checks, cyc, t_cke, t_start, n_dll;
    logic [3:0]  q_cmd[$];             // logged command codes
    logic [1:0]  q_ba[$];
    logic [13:0] q_addr[$];
    int          q_cyc[$];             // cycle of each logged command
    logic        cke_prev;

    ddr2_link_if u_ddr2_link_if();
    ddr2_init_ctrl #(.STABLE_CYCLES(STAB)) u_ddr2_init_ctrl (.CLK(clk), .RST_N(rst_n),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .link(u_ddr2_link_if));
    ddr2_init_mem u_ddr2_init_mem (.CLK(clk), .RST_N(rst_n), .link(u_ddr2_link_if), .READY(ready),
        .DLL_RESET(dll_reset), .ODT_ACTIVE(odt_active), .MR_OUT(mr_out), .EMR1_OUT(emr1_out),
        .EMR2_OUT(emr2_out), .EMR3_OUT(emr3_out));
    ddr2_init_assertions u_ddr2_init_assertions (.CLK(clk), .RST_N(rst_n), .cke(u_ddr2_link_if.cke),
        .odt(u_ddr2_link_if.odt), .cs_n(u_ddr2_link_if.cs_n), .ras_n(u_ddr2_link_if.ras_n),
        .cas_n(u_ddr2_link_if.cas_n), .we_n(u_ddr2_link_if.we_n), .ba(u_ddr2_link_if.ba),
        .addr(u_ddr2_link_if.addr));

    // free-running clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // link monitor: logs commands, cke rise and dll reset pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        cke_prev <= u_ddr2_link_if.cke;
        if (rst_n && u_ddr2_link_if.cke && !u_ddr2_link_if.cs_n &&
            {u_ddr2_link_if.ras_n, u_ddr2_link_if.cas_n, u_ddr2_link_if.we_n} != 3'h7) begin
            q_cmd.push_back({u_ddr2_link_if.cs_n, u_ddr2_link_if.ras_n, u_ddr2_link_if.cas_n, u_ddr2_link_if.we_n});
            q_ba.push_back(u_ddr2_link_if.ba);
            q_addr.push_back(u_ddr2_link_if.addr);
            q_cyc.push_back(cyc);
        end
        if (u_ddr2_link_if.cke === 1'b1 && cke_prev === 1'b0) t_cke = cyc;
        if (dll_reset === 1'b1) n_dll++;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one Avalon transfer: hold the request until waitrequest is sampled low
    task avs(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : avs

    task wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        avs(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [2:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        avs(1'b0, a, 32'h0000_0000, q);
        chk(q & mask, exp);
    endtask : rd

    // program the four images, run the sequence, then compare the link log and the device images
    task run_init(input logic [13:0] mr, input logic [13:0] e1, input logic [13:0] e2, input logic [13:0] e3);
        logic [13:0] m;
        logic [13:0] ea[11];
        logic [13:0] em[11];
        logic [3:0]  ec[11];
        logic [1:0]  eb[11];
        logic [31:0] q;
        int          i;
        m = mr & 14'h3F7F;
        ec = '{CMD_PREALL, CMD_MRS, CMD_MRS, CMD_MRS, CMD_MRS, CMD_PREALL, CMD_REF, CMD_REF, CMD_MRS, CMD_MRS, CMD_MRS};
        eb = '{BANK_MR, BANK_EMR2, BANK_EMR3, BANK_EMR1, BANK_MR, BANK_MR, BANK_MR, BANK_MR, BANK_MR, BANK_EMR1, BANK_EMR1};
        ea = '{14'h0400, e2, e3, e1, m | 14'h0100, 14'h0400, ZERO_ADDR, ZERO_ADDR, m, e1 | OCD_MASK, e1};
        em = '{14'h0400, '1, '1, '1, '1, 14'h0400, ZERO_ADDR, ZERO_ADDR, '1, '1, '1};
        wr(3'h2, {18'h0, mr});
        wr(3'h3, {18'h0, e1});
        wr(3'h4, {18'h0, e2});
        wr(3'h5, {18'h0, e3});
        wr(3'h6, 32'h0000_1234);
        rd(3'h2, 32'hFFFF_FFFF, {18'h0, m});
        rd(3'h3, 32'hFFFF_FFFF, {18'h0, e1});
        rd(3'h4, 32'hFFFF_FFFF, {18'h0, e2});
        rd(3'h5, 32'hFFFF_FFFF, {18'h0, e3});
        rd(3'h6, 32'hFFFF_FFFF, 32'h0000_0000);
        q_cmd.delete();
        q_ba.delete();
        q_addr.delete();
        q_cyc.delete();
        n_dll = 0;
        wr(3'h0, 32'h0000_0001);
        t_start = cyc;
        rd(3'h0, 32'h0000_0001, 32'h0000_0000);
        i = 0;
        do begin
            avs(1'b0, 3'h1, 32'h0000_0000, q);
            i++;
        end while (q[1] !== 1'b1 && i < 500);
        chk(q & 32'h0000_0003, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk(q_cmd.size(), 11);
        for (i = 0; i < 11 && i < q_cmd.size(); i++) begin
            chk({q_cmd[i], q_cmd[i] == CMD_MRS ? q_ba[i] : BANK_MR, q_addr[i] & em[i]}, {ec[i], eb[i], ea[i]});
        end
        if (q_cmd.size() == 11) begin
            chk(q_cyc[9] - q_cyc[4] >= DLL_LOCK_CLKS, 1);
            chk(q_cyc[0] - t_cke >= CKE_NOP_CYC, 1);
        end
        chk(t_cke - t_start >= STAB, 1);
        chk(n_dll, 1);
        chk({ready, odt_active}, 2'b10);
        chk({mr_out, emr1_out}, {m, e1});
        chk({emr2_out, emr3_out}, {e2, e3});
    endtask : run_init

    task summarize;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // watchdog: the whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {rst_n, n_mismatch, checks, cyc, t_cke, t_start, n_dll, cke_prev} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({u_ddr2_link_if.cke, u_ddr2_link_if.cs_n, ready}, 3'b010);
        rd(3'h1, 32'h0000_0003, 32'h0000_0000);
        $display("test reset done");
        run_init(14'h04D3, 14'h0004, 14'h0080, 14'h0000);
        $display("test first init done");
        wr(3'h0, 32'h0000_0001);
        repeat (60) @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({u_ddr2_link_if.cke, ready, mr_out}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        run_init(14'h0A62, 14'h0044, 14'h0000, 14'h0001);
        $display("test reinit done");
        summarize();
    end
endmodule : testbench
